// >>> verilog/asr_pkg.sv
// constants and types for the serial readout port of the converter
package asr_pkg;

  // word sizes
  localparam int unsigned DATA_BITS   = 32;  // bits shifted out per readout
  localparam int unsigned CFG_BITS    = 13;  // input bits needed to store settings
  localparam int unsigned MUX_FALL    = 14;  // falling edge that switches the channel
  localparam int unsigned CHAN_BITS   = 8;   // channel and reference select field
  localparam int unsigned OSR_BITS    = 4;   // oversample code field

  // timing
  localparam int unsigned CLK_MHZ            = 125;  // system clock rate
  localparam int unsigned DONE_TEST_DELAY_NS = 500;  // sleep before internal readout
  // least time, so round up to whole cycles
  localparam int unsigned DONE_TEST_CYC = (DONE_TEST_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SCK_HALF_CYC  = 8;    // default half period of internal clock

  // reset values of the settings
  localparam logic [CHAN_BITS-1:0] CHAN_RST = 8'h00;
  localparam logic [OSR_BITS-1:0]  OSR_RST  = 4'hF;
  localparam logic                 DBL_RST  = 1'b0;

  // settings carried by the input word, first bit in is chan msb
  typedef struct packed {
    logic [CHAN_BITS-1:0] chan;                    // channel and reference select
    logic [OSR_BITS-1:0]  oversample_code;         // msb is oversample_code_msb
    logic                 double_rate_select;      // last bit of the rate field
  } asr_cfg_t;

  // two-way serial clock pin
  typedef struct packed {
    logic o;   // level driven
    logic oe;  // high while driving
  } asr_pin_t;

  // converter states
  typedef enum logic [1:0] {ST_CONV, ST_SLEEP, ST_SHIFT} asr_state_t;

endpackage : asr_pkg

// >>> verilog/asr_sync.sv
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module asr_sync #(
  parameter int unsigned W = 1  // number of bits
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;  // first stage, read by the second stage only

  // both stages reset high so idle chip select reads as deasserted
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : asr_sync

// >>> verilog/asr_tick.sv
// enable pulse divider for the internally made serial clock
`timescale 1ns/1ps
module asr_tick #(
  parameter int unsigned HALF = 8  // cycles between pulses
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic run,
  output logic      tick
);
  logic [15:0] cnt_q;  // cycles since last pulse

  // counter restarts whenever run drops, so each burst starts evenly
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q == 16'(HALF - 1)) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule : asr_tick

// >>> verilog/asr_port.sv
// serial readout and configuration port: four timing modes
`timescale 1ns/1ps
module asr_port
  import asr_pkg::*;
#(
  parameter int unsigned SCK_HALF = asr_pkg::SCK_HALF_CYC  // internal clock half period
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  clock_source_select,
  input  wire logic                  cs_n,
  input  wire logic                  sck_i,
  output asr_pkg::asr_pin_t          sck,
  input  wire logic                  sdi,
  output logic                       sdo_o,
  output logic                       sdo_oe,
  output logic                       busy,
  input  wire logic                  conv_done,
  input  wire logic [asr_pkg::DATA_BITS-2:0] conv_result,
  output logic                       conv_start,
  output asr_pkg::asr_cfg_t          cfg,
  output logic                       mux_switch
);
  import asr_pkg::*;

  // synchronised pins
  logic [3:0]  pins_s;         // select, chip select, clock, data in
  logic        int_mode;       // high: internal serial clock
  logic        cs_low;         // chip select asserted
  logic        sck_s;          // external clock after the synchroniser
  logic        sdi_s;          // data in, aligned with sck_s
  logic        sck_prev_q;     // for edge finding on the clock pin
  logic        cs_prev_q;      // for edge finding on chip select

  // state
  asr_state_t             state_q;      // convert, sleep or shift
  logic [DATA_BITS-1:0]   shift_q;      // static output shifter
  logic [CFG_BITS-1:0]    in_q;         // input word being collected
  logic [5:0]             rise_cnt_q;   // rising edges seen this readout
  logic [5:0]             fall_cnt_q;   // falling edges seen this readout
  logic [6:0]             dly_cnt_q;    // sleep time before internal readout
  logic                   sck_q;        // internal clock level
  logic                   tick;         // half period enable
  logic [1:0]             settle_q;     // synchroniser filled since reset

  // events
  logic ext_rise;    // synchronised rising edge of external clock
  logic ext_fall;    // synchronised falling edge of external clock
  logic cs_rise;     // chip select released
  logic cs_fall;     // chip select asserted
  logic dly_done;    // internal readout may begin
  logic rise_ev;     // a readout rising edge in either mode
  logic fall_ev;     // a readout falling edge in either mode
  logic last_edge;   // edge that ends a full readout
  logic abort_ev;    // readout cut short by chip select
  logic start_conv;  // begin a new conversion now
  logic word_ok;     // enough input bits for a valid word
  asr_cfg_t new_cfg; // decoded input word

  asr_sync #(
    .W (4)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({clock_source_select, cs_n, sck_i, sdi}),
    .sync_out (pins_s)
  );

  asr_tick #(
    .HALF (SCK_HALF)
  ) u_tick (
    .clk    (clk),
    .resetn (resetn),
    .run    (state_q == ST_SHIFT && int_mode),
    .tick   (tick)
  );

  assign int_mode = pins_s[3];
  assign cs_low   = !pins_s[2];
  assign sck_s    = pins_s[1];
  assign sdi_s    = pins_s[0];
  assign new_cfg  = in_q;

  // edge history of clock and chip select
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_prev_q <= 1'b1;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= pins_s[2];
    end
  end

  // the synchroniser reads all ones for two cycles after reset, which looks
  // like internal mode and would drive the clock pin against the host
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settle_q <= 2'b00;
    end else begin
      settle_q <= {settle_q[0], 1'b1};
    end
  end

  assign ext_rise = !int_mode && sck_s && !sck_prev_q;
  assign ext_fall = !int_mode && !sck_s && sck_prev_q;
  assign cs_rise  = pins_s[2] && !cs_prev_q;
  assign cs_fall  = !pins_s[2] && cs_prev_q;
  assign dly_done = dly_cnt_q == 7'(DONE_TEST_CYC - 1);
  assign word_ok  = rise_cnt_q >= 6'(CFG_BITS);

  // a readout edge: external edges only while readout runs or wakes, the
  // first internal rise comes straight from the end of the sleep delay
  always_comb begin
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    if (int_mode) begin
      rise_ev = (state_q == ST_SLEEP && cs_low && dly_done)
             || (state_q == ST_SHIFT && tick && !sck_q);
      fall_ev = state_q == ST_SHIFT && tick && sck_q;
    end else begin
      rise_ev = ext_rise && ((state_q == ST_SLEEP && cs_low)
             || state_q == ST_SHIFT);
      fall_ev = ext_fall && state_q == ST_SHIFT;
    end
  end

  // external mode ends on the 32nd fall, internal on the 32nd rise
  assign last_edge = int_mode ? (rise_ev && rise_cnt_q == 6'(DATA_BITS - 1))
                              : (fall_ev && fall_cnt_q == 6'(DATA_BITS - 1));
  assign abort_ev   = state_q == ST_SHIFT && cs_rise;
  assign start_conv = state_q == ST_SHIFT && (last_edge || abort_ev);

  // main sequence: convert, sleep holding the result, shift it out
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_CONV;
    end else begin
      unique case (state_q)
        ST_CONV: begin
          // sleep follows completion whatever chip select does
          if (conv_done) begin
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // stays asleep until a readout edge arrives
          if (rise_ev) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // full readout or abort both restart conversion
          if (start_conv) begin
            state_q <= ST_CONV;
          end
        end
      endcase
    end
  end

  // output shifter: result loads while done is high in convert, moves on each fall
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= '1;
    end else if (state_q == ST_CONV && conv_done) begin
      shift_q <= {1'b0, conv_result};
    end else if (fall_ev) begin
      shift_q <= {shift_q[DATA_BITS-2:0], 1'b1};
    end
  end

  // edge counters, cleared when a new conversion starts
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rise_cnt_q <= 6'h00;
      fall_cnt_q <= 6'h00;
    end else if (state_q == ST_CONV) begin
      rise_cnt_q <= 6'h00;
      fall_cnt_q <= 6'h00;
    end else begin
      if (rise_ev) begin
        rise_cnt_q <= rise_cnt_q + 6'h01;
      end
      if (fall_ev) begin
        fall_cnt_q <= fall_cnt_q + 6'h01;
      end
    end
  end

  // input word: sampled on rising edges, bits past thirteen dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_q <= '0;
    end else if (rise_ev && !word_ok) begin
      in_q <= {in_q[CFG_BITS-2:0], sdi_s};
    end
  end

  // sleep delay before internal readout; chip select high resets it, so
  // an early release leaves the device asleep with the result kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dly_cnt_q <= 7'h00;
    end else if (state_q != ST_SLEEP || !int_mode || !cs_low) begin
      dly_cnt_q <= 7'h00;
    end else if (!dly_done) begin
      dly_cnt_q <= dly_cnt_q + 7'h01;
    end
  end

  // internal serial clock level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_q <= 1'b1;
    end else if (start_conv) begin
      sck_q <= 1'b1;
    end else if (rise_ev) begin
      sck_q <= 1'b1;
    end else if (fall_ev) begin
      sck_q <= 1'b0;
    end else if (state_q == ST_CONV && conv_done) begin
      sck_q <= 1'b0;
    end else if (cs_fall && state_q != ST_SHIFT) begin
      sck_q <= 1'b0;
    end
  end

  // settings: stored only with a full word, used from the next conversion;
  // the channel may move early at the 14th fall in single rate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg.chan               <= CHAN_RST;
      cfg.oversample_code    <= OSR_RST;
      cfg.double_rate_select <= DBL_RST;
      mux_switch             <= 1'b0;
    end else begin
      mux_switch <= 1'b0;
      if (fall_ev && fall_cnt_q == 6'(MUX_FALL - 1) && word_ok
          && !cfg.double_rate_select && new_cfg.chan != cfg.chan) begin
        cfg.chan   <= new_cfg.chan;
        mux_switch <= 1'b1;
      end
      if (start_conv && word_ok) begin
        cfg.chan <= new_cfg.chan;
        // a zero oversample code leaves rate and resolution alone
        if (new_cfg.oversample_code != '0) begin
          cfg.oversample_code    <= new_cfg.oversample_code;
          cfg.double_rate_select <= new_cfg.double_rate_select;
        end
      end
    end
  end

  // conversion start pulse; reset itself begins the first conversion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_start <= 1'b1;
    end else begin
      conv_start <= start_conv;
    end
  end

  // pin outputs, all registered; they trail the state by one cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sdo_o  <= 1'b1;
      sdo_oe <= 1'b0;
      busy   <= 1'b1;
      sck.o  <= 1'b1;
      sck.oe <= 1'b0;
    end else begin
      // done flag while converting, shifter msb otherwise
      sdo_o  <= (state_q == ST_CONV) ? 1'b1 : shift_q[DATA_BITS-1];
      sdo_oe <= cs_low;
      busy   <= state_q == ST_CONV;
      sck.o  <= sck_q;
      sck.oe <= int_mode && settle_q[1];
    end
  end

endmodule : asr_port

// >>> tb/asr_port_props.sv
// concurrent checks on the ports of the serial readout port
`timescale 1ns/1ps
module asr_port_props
  import asr_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          resetn,
  input wire logic                          clock_source_select,
  input wire logic                          cs_n,
  input wire logic                          sck_i,
  input wire asr_pkg::asr_pin_t             sck,
  input wire logic                          sdi,
  input wire logic                          sdo_o,
  input wire logic                          sdo_oe,
  input wire logic                          busy,
  input wire logic                          conv_done,
  input wire logic [asr_pkg::DATA_BITS-2:0] conv_result,
  input wire logic                          conv_start,
  input wire asr_pkg::asr_cfg_t             cfg,
  input wire logic                          mux_switch
);
  import asr_pkg::*;
  // one domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_sdo_float: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("data output driven while deselected");
  chk_flag_conv: assert property (sdo_oe && busy |-> sdo_o)
    else $error("flag low while converting");
  chk_done_sleep: assert property (conv_done |-> ##2 (!busy && !sdo_o))
    else $error("no sleep after completion");
  chk_busy_rise: assert property ($rose(busy) |-> sdo_o)
    else $error("busy rose with data output low");
  chk_busy_hold: assert property (!busy && !conv_start && !$past(conv_start) |=> !busy)
    else $error("busy rose without a new conversion");
  chk_start_busy: assert property ($rose(conv_start) |-> ##[0:2] busy)
    else $error("conversion start without busy");
  chk_sck_sleep: assert property (conv_done && sck.oe |-> ##2 !sck.o)
    else $error("internal clock not low in sleep");
  chk_sck_conv: assert property (busy && sck.oe && ($rose(busy) ||
    ($past(sck.o) && $past(sdo_oe, 2) == sdo_oe)) |-> sck.o)
    else $error("internal clock low while converting");
  chk_auto_delay: assert property (conv_done && sck.oe && !cs_n |-> ##[60:70] $rose(sck.o))
    else $error("readout delay out of range");
  chk_cfg_moves: assert property ($changed(cfg) |->
    conv_start || mux_switch || $past(conv_start) || $past(mux_switch))
    else $error("settings changed outside a conversion start");
  chk_mux_single: assert property (mux_switch |-> !cfg.double_rate_select)
    else $error("channel switch pulse in double rate");
endmodule : asr_port_props

bind asr_port asr_port_props asr_port_props_inst (.clk(clk), .resetn(resetn),
  .clock_source_select(clock_source_select), .cs_n(cs_n), .sck_i(sck_i), .sck(sck),
  .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .busy(busy), .conv_done(conv_done),
  .conv_result(conv_result), .conv_start(conv_start), .cfg(cfg), .mux_switch(mux_switch));

// >>> tb/asr_host.sv
// host side model: serial master for both clock sources
`timescale 1ns/1ps
module asr_host
  import asr_pkg::*;
(
  input wire asr_pkg::asr_pin_t sck,
  input wire logic              sdo_o,
  input wire logic              sdo_oe,
  output logic                  clock_source_select,
  output logic                  cs_n,
  output wire logic             sck_i,
  output logic                  sdi
);
  import asr_pkg::*;
  logic        sck_h;  // level the host puts on the clock wire
  logic [31:0] din;    // word still to send, first bit at the top
  logic [31:0] cap;    // bits latched from the data wire
  int          nrise;  // internal clock rises seen since arming
  // no pull on the data wire, so a released line reads unknown
  wire sdo_w = sdo_oe ? sdo_o : 1'bz;
  // a latching host needs hold time: read the data wire as it stood just
  // before the clock edge, since the device may move it on that same edge
  wire sdo_held;
  assign #1 sdo_held = sdo_w;
  // the clock wire carries whichever party is driving it
  assign sck_i = sck.oe ? sck.o : sck_h;
  initial begin
    clock_source_select = 1'b0;
    cs_n = 1'b1;
    sck_h = 1'b0;
    sdi = 1'b0;
    din = '0;
    cap = '0;
    nrise = 0;
  end
  // internal clock: latch on rises, send on falls
  always @(posedge sck_i) if (sck.oe) begin
    cap <= {cap[30:0], sdo_held};
    nrise <= nrise + 1;
  end
  always @(negedge sck_i) if (sck.oe) begin
    sdi <= din[31];
    din <= din << 1;
  end
  task automatic pins(input logic src, input logic cs);
    clock_source_select = src;
    cs_n = cs;
  endtask : pins
  task automatic arm(input logic [31:0] w);
    din = w;
    cap = '0;
    nrise = 0;
  endtask : arm
  // external clock frame of n bits at an 80 ns period
  task automatic ext_xfer(input int n, input logic [31:0] w);
    arm(w);
    for (int i = 0; i < n; i++) begin
      sdi = din[31];
      din = din << 1;
      #40 sck_h = 1'b1;
      // output lags the pins by several system cycles, so latch late in the high phase
      #38 cap = {cap[30:0], sdo_w};
      #2 sck_h = 1'b0;
    end
    sdi = ~sdi;
  endtask : ext_xfer
endmodule : asr_host

// >>> tb/tb_top.sv
// testbench: all four timing modes through the host model
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_total++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
  import asr_pkg::*;
  logic        clk, resetn, clock_source_select, cs_n, sck_i, sdi;
  logic        sdo_o, sdo_oe, busy, conv_done, conv_start, mux_switch, mux_seen;
  asr_pin_t    sck;
  asr_cfg_t    cfg;
  logic [30:0] conv_result;
  int          err_total, check_count, cnt;
  asr_port #(.SCK_HALF(8)) asr_port_inst (.clk(clk), .resetn(resetn),
    .clock_source_select(clock_source_select), .cs_n(cs_n), .sck_i(sck_i), .sck(sck),
    .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .busy(busy), .conv_done(conv_done),
    .conv_result(conv_result), .conv_start(conv_start), .cfg(cfg), .mux_switch(mux_switch));
  asr_host asr_host_inst (.sck(sck), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .clock_source_select(clock_source_select), .cs_n(cs_n), .sck_i(sck_i), .sdi(sdi));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // converter stand-in: completes 40 cycles after each start
  always @(negedge clk) begin
    conv_done <= 1'b0;
    if (conv_start) cnt <= 40;
    else if (cnt == 1) conv_done <= 1'b1;
    if (!conv_start && cnt > 0) cnt <= cnt - 1;
    if (mux_switch) mux_seen <= 1'b1;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic wait_busy(input logic v);
    for (int n = 0; n < 2000 && busy !== v; n++) @(negedge clk);
    `CHK("busy", v, busy)
  endtask : wait_busy
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  initial begin
    {resetn, conv_done, mux_seen, cnt, err_total, check_count} = '0;
    conv_result = 31'h5A3C0F1E;
    idle(5);
    resetn = 1'b1;
    // external clock, chip select frame, new channel
    wait_busy(0);
    `CHK("oe", 1'b0, sdo_oe)
    asr_host_inst.pins(1'b0, 1'b0);
    idle(6);
    `CHK("flag", 2'b10, {sdo_oe, sdo_o})
    asr_host_inst.ext_xfer(32, {8'h35, 4'h3, 1'b0, 19'h0});
    `CHK("data", {1'b0, 31'h5A3C0F1E}, asr_host_inst.cap)
    `CHK("mux", 1'b1, mux_seen)
    idle(10);
    `CHK("flag", 2'b11, {busy, sdo_o})
    `CHK("cfg", {8'h35, 4'h3, 1'b0}, cfg)
    $display("test external frame done");
    // abort after eight bits keeps the settings
    wait_busy(0);
    asr_host_inst.ext_xfer(8, {8'hC7, 24'h0});
    asr_host_inst.pins(1'b0, 1'b1);
    idle(10);
    `CHK("busy", 1'b1, busy)
    `CHK("cfg", {8'h35, 4'h3, 1'b0}, cfg)
    $display("test external abort done");
    // chip select held low, zero oversample code
    conv_result = 31'h12345678;
    asr_host_inst.pins(1'b0, 1'b0);
    mux_seen = 1'b0;
    wait_busy(0);
    asr_host_inst.ext_xfer(32, {8'h35, 4'h0, 1'b1, 19'h7FFFF});
    `CHK("data", {1'b0, 31'h12345678}, asr_host_inst.cap)
    idle(10);
    `CHK("cfg", {8'h35, 4'h3, 1'b0}, cfg)
    `CHK("mux", 1'b0, mux_seen)
    $display("test three wire done");
    // internal clock, continuous
    asr_host_inst.pins(1'b1, 1'b0);
    idle(8);
    asr_host_inst.arm({8'h9A, 4'h5, 1'b1, 19'h0});
    wait_busy(0);
    wait_busy(1);
    `CHK("data", {1'b0, 31'h12345678}, asr_host_inst.cap)
    `CHK("rises", 32'd32, asr_host_inst.nrise)
    `CHK("sck", 1'b1, sck.o)
    idle(2);
    `CHK("cfg", {8'h9A, 4'h5, 1'b1}, cfg)
    $display("test internal continuous done");
    // internal, chip select controlled: early release, then abort
    asr_host_inst.pins(1'b1, 1'b1);
    idle(4);
    asr_host_inst.pins(1'b1, 1'b0);
    idle(6);
    `CHK("sck", 3'b110, {busy, sdo_oe, sck.o})
    asr_host_inst.pins(1'b1, 1'b1);
    wait_busy(0);
    asr_host_inst.arm('0);
    asr_host_inst.pins(1'b1, 1'b0);
    idle(20);
    asr_host_inst.pins(1'b1, 1'b1);
    idle(100);
    `CHK("busy", 1'b0, busy)
    `CHK("rises", 32'd0, asr_host_inst.nrise)
    asr_host_inst.pins(1'b1, 1'b0);
    for (int n = 0; n < 400 && asr_host_inst.nrise < 5; n++) @(negedge clk);
    asr_host_inst.pins(1'b1, 1'b1);
    idle(10);
    `CHK("busy", 1'b1, busy)
    `CHK("cfg", {8'h9A, 4'h5, 1'b1}, cfg)
    $display("test internal abort done");
    conclude();
  end
  // watchdog: the tests need well under 5000 cycles
  initial begin
    #160000;
    err_total++;
    conclude();
  end
endmodule : tb_top
